// ---- src/gpio_ports.sv ----
`timescale 1ns/10ps
`include "gpio_ports_defs.svh"

module gpio_ports #(
  parameter int ADDR_W = 8  // axi address width
) (
  input  wire logic              mclk_i,                  // cpu clock, 10 MHz
  input  wire logic              resetn_i,                // async reset, active low
  input  wire logic              ce_i,                    // clock enable, freezes state
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,            // write address
  input  wire logic              s_axi_awvalid,           // write address valid
  output logic                   s_axi_awready,           // write address ready
  input  wire logic [31:0]       s_axi_wdata,             // write data
  input  wire logic [3:0]        s_axi_wstrb,             // write byte enables
  input  wire logic              s_axi_wvalid,            // write data valid
  output logic                   s_axi_wready,            // write data ready
  output logic [1:0]             s_axi_bresp,             // write response
  output logic                   s_axi_bvalid,            // write response valid
  input  wire logic              s_axi_bready,            // write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,            // read address
  input  wire logic              s_axi_arvalid,           // read address valid
  output logic                   s_axi_arready,           // read address ready
  output logic [31:0]            s_axi_rdata,             // read data
  output logic [1:0]             s_axi_rresp,             // read response
  output logic                   s_axi_rvalid,            // read data valid
  input  wire logic              s_axi_rready,            // read data ready
  // analog-shared input port
  input  wire logic [7:0]        analog_pin_i,            // input-only pins
  output logic [7:0]             analog_input_o,          // to the converter
  // port b pins, physical order (register bits 0,1,2,6,7)
  input  wire logic [4:0]        port_b_pin_i,            // pin level
  output logic [4:0]             port_b_pin_o,            // pin drive value
  output logic [4:0]             port_b_pin_oe_o,         // pin drive enable
  output logic [4:0]             port_b_pullup_o,         // pull-up enable
  // port c pins
  input  wire logic [3:0]        port_c_pin_i,            // pin level
  output logic [3:0]             port_c_pin_o,            // pin drive value
  output logic [3:0]             port_c_pin_oe_o,         // pin drive enable
  output logic [3:0]             port_c_pullup_o,         // pull-up enable
  // peripheral outputs to pins
  input  wire logic              serial_five_clock_i,     // serial 5 clock out
  input  wire logic              serial_five_data_out_i,  // serial 5 data out
  input  wire logic              analog_output_zero_i,    // analog output 0
  input  wire logic              analog_output_one_i,     // analog output 1
  input  wire logic              async_six_transmit_data_i,  // async 6 tx data
  input  wire logic              async_six_receive_clock_i,  // async 6 rx clock out
  input  wire logic              async_six_transmit_clock_i, // async 6 tx clock out
  // peripheral inputs from pins (synchronised)
  output logic                   serial_five_clock_in_o,     // serial 5 clock in
  output logic                   serial_five_data_in_o,      // serial 5 data in
  output logic                   async_six_receive_data_o,   // async 6 rx data
  output logic                   async_six_receive_clock_in_o,  // async 6 rx clock in
  output logic                   async_six_transmit_clock_in_o  // async 6 tx clock in
);

  // spread five physical port b bits onto their register positions
  function automatic logic [7:0] b_expand(input logic [4:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[`POS_B0] = v[0];
    r[`POS_B1] = v[1];
    r[`POS_B2] = v[2];
    r[`POS_B3] = v[3];
    r[`POS_B4] = v[4];
    return r;
  endfunction

  // gather the five port b bits from a register image
  function automatic logic [4:0] b_pack(input logic [7:0] v);
    return {v[`POS_B4], v[`POS_B3], v[`POS_B2], v[`POS_B1], v[`POS_B0]};
  endfunction

  // per-bit read selection, shared by both bidirectional ports
  function automatic logic bit_read(input logic pin, input logic data,
                                    input logic dir, input logic alt,
                                    input logic periph);
    return dir ? (alt ? periph : data) : pin;
  endfunction

  // byte-lane merge of a write onto an 8-bit register image
  function automatic logic [7:0] lane0(input logic [7:0] old_v,
                                       input logic [31:0] wd,
                                       input logic [3:0] st);
    return st[0] ? wd[7:0] : old_v;
  endfunction

  logic [1:0]                     rst_sync;       // reset release synchroniser
  logic                           rst_n;          // synchronised reset
  logic [16:0]                    pin_s1;         // first sync stage
  logic [16:0]                    pin_s2;         // second sync stage
  logic [16:0]                    pin_s3;         // third sync stage
  logic [16:0]                    pin_q;          // accepted pin levels
  logic [7:0]                     analog_q;       // synced analog pin levels
  logic [4:0]                     b_pin_q;        // synced port b levels
  logic [3:0]                     c_pin_q;        // synced port c levels
  gpio_ports_pkg::port_b_cfg_type b_cfg;          // port b registers
  gpio_ports_pkg::port_c_cfg_type c_cfg;          // port c registers
  logic [4:0]                     b_periph;       // port b peripheral outputs
  logic [3:0]                     c_periph;       // port c peripheral outputs
  logic [4:0]                     b_read;         // port b read mux
  logic [3:0]                     c_read;         // port c read mux
  logic [4:0]                     next_b_pin;     // port b drive value
  logic [3:0]                     next_c_pin;     // port c drive value
  gpio_ports_pkg::chan_state_type wr_state;       // write channel state
  gpio_ports_pkg::chan_state_type rd_state;       // read channel state
  logic                           wr_take;        // write address and data taken
  logic                           rd_take;        // read address taken
  logic [7:0]                     next_rdata;     // read decode result
  logic                           next_rhit;      // read address mapped

  // reset is applied at once but released through two flops
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // three-stage pin synchroniser; stage one feeds only stage two
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 17'h00000;
      pin_s2 <= 17'h00000;
      pin_s3 <= 17'h00000;
    end
    else if (ce_i)
    begin
      pin_s1 <= {port_c_pin_i, port_b_pin_i, analog_pin_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // a bit reads 1 only while stages two and three agree on 1; any disagreement clears it to 0
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      pin_q <= 17'h00000;
    else if (ce_i)
      pin_q <= (pin_q & ~(pin_s2 ^ pin_s3)) | (pin_s2 & ~(pin_s2 ^ pin_s3));
  end

  assign analog_q = pin_q[7:0];
  assign b_pin_q  = pin_q[12:8];
  assign c_pin_q  = pin_q[16:13];

  // converter sees the very same pin, unsynchronised as analog demands
  assign analog_input_o = analog_pin_i;

  // peripheral inputs tap the synchronised pin levels ahead of the read mux, so they follow the pin whatever dir is
  assign serial_five_clock_in_o        = b_pin_q[0];
  assign serial_five_data_in_o         = b_pin_q[2];
  assign async_six_receive_data_o      = c_pin_q[0];
  assign async_six_receive_clock_in_o  = c_pin_q[2];
  assign async_six_transmit_clock_in_o = c_pin_q[3];

  // peripheral output per bit; fixed-low bits carry a constant 0
  always_comb
  begin
    b_periph = {analog_output_one_i, analog_output_zero_i, 1'b0,
                serial_five_data_out_i, serial_five_clock_i};
    b_periph[`IDX_B_FIXED_LOW] = 1'b0;
    c_periph = {async_six_transmit_clock_i, async_six_receive_clock_i,
                async_six_transmit_data_i, 1'b0};
    c_periph[`IDX_C_FIXED_LOW] = 1'b0;
  end

  // read mux and pin drive value, one bit at a time
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_b
      assign b_read[gi] = bit_read(b_pin_q[gi], b_cfg.data[gi], b_cfg.dir[gi],
                                   b_cfg.alt[gi], b_periph[gi]);
      assign next_b_pin[gi] = b_cfg.alt[gi] ? b_periph[gi] : b_cfg.data[gi];
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_c
      assign c_read[gi] = bit_read(c_pin_q[gi], c_cfg.data[gi], c_cfg.dir[gi],
                                   c_cfg.alt[gi], c_periph[gi]);
      assign next_c_pin[gi] = c_cfg.alt[gi] ? c_periph[gi] : c_cfg.data[gi];
    end
  endgenerate

  // pin drivers are registered so the pads never see a decode glitch
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_b_pin_o    <= `RST_PORT_B;
      port_b_pin_oe_o <= `RST_PORT_B;
      port_b_pullup_o <= `RST_PORT_B;
      port_c_pin_o    <= `RST_PORT_C;
      port_c_pin_oe_o <= `RST_PORT_C;
      port_c_pullup_o <= `RST_PORT_C;
    end
    else if (ce_i)
    begin
      port_b_pin_o    <= next_b_pin;
      port_b_pin_oe_o <= b_cfg.dir;
      port_b_pullup_o <= ~b_cfg.dir & b_cfg.alt;
      port_c_pin_o    <= next_c_pin;
      port_c_pin_oe_o <= c_cfg.dir;
      port_c_pullup_o <= ~c_cfg.dir & c_cfg.alt;
    end
  end

  // write channel: address and data are taken in the same cycle
  assign wr_take       = (wr_state == gpio_ports_pkg::CH_IDLE) & s_axi_awvalid & s_axi_wvalid
    & ce_i;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_state     <= gpio_ports_pkg::CH_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (ce_i)
    begin
      unique case (wr_state)
        gpio_ports_pkg::CH_IDLE:
        begin
          if (wr_take)
          begin
            wr_state     <= gpio_ports_pkg::CH_RESP;
            s_axi_bvalid <= 1'b1;
            // the analog port is read only, so it answers like an unmapped word
            unique case (s_axi_awaddr)
              `OFS_PORT_B_DATA, `OFS_PORT_B_DIRECTION, `OFS_PORT_B_ALT_FUNCTION,
              `OFS_PORT_C_DATA, `OFS_PORT_C_DIRECTION, `OFS_PORT_C_ALT_FUNCTION:
                s_axi_bresp <= `RESP_OKAY;
              default:
                s_axi_bresp <= `RESP_SLVERR;
            endcase
          end
        end
        gpio_ports_pkg::CH_RESP:
        begin
          if (s_axi_bready)
          begin
            wr_state     <= gpio_ports_pkg::CH_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // register file; only existing bits are stored, so missing ones read 0
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      b_cfg <= {`RST_PORT_B, `RST_PORT_B, `RST_PORT_B};
      c_cfg <= {`RST_PORT_C, `RST_PORT_C, `RST_PORT_C};
    end
    else if (ce_i && wr_take)
    begin
      // a read-modify-write reads the mux and writes the result here
      unique case (s_axi_awaddr)
        `OFS_PORT_B_DATA:
          b_cfg.data <= b_pack(lane0(b_expand(b_cfg.data), s_axi_wdata, s_axi_wstrb));
        `OFS_PORT_B_DIRECTION:
          b_cfg.dir <= b_pack(lane0(b_expand(b_cfg.dir), s_axi_wdata, s_axi_wstrb));
        `OFS_PORT_B_ALT_FUNCTION:
          b_cfg.alt <= b_pack(lane0(b_expand(b_cfg.alt), s_axi_wdata, s_axi_wstrb));
        `OFS_PORT_C_DATA:
          c_cfg.data <= 4'(lane0({4'h0, c_cfg.data}, s_axi_wdata, s_axi_wstrb));
        `OFS_PORT_C_DIRECTION:
          c_cfg.dir <= 4'(lane0({4'h0, c_cfg.dir}, s_axi_wdata, s_axi_wstrb));
        `OFS_PORT_C_ALT_FUNCTION:
          c_cfg.alt <= 4'(lane0({4'h0, c_cfg.alt}, s_axi_wdata, s_axi_wstrb));
        default:
        begin
          // unmapped or read-only: nothing stored
        end
      endcase
    end
  end

  // read decode; the analog port has no control registers and no pull-ups
  always_comb
  begin
    next_rhit = 1'b1;
    unique case (s_axi_araddr)
      `OFS_ANALOG_PORT_PIN_LEVELS: next_rdata = analog_q;
      `OFS_PORT_B_DATA:            next_rdata = b_expand(b_read);
      `OFS_PORT_B_DIRECTION:       next_rdata = b_expand(b_cfg.dir);
      `OFS_PORT_B_ALT_FUNCTION:    next_rdata = b_expand(b_cfg.alt);
      `OFS_PORT_C_DATA:            next_rdata = {4'h0, c_read};
      `OFS_PORT_C_DIRECTION:       next_rdata = {4'h0, c_cfg.dir};
      `OFS_PORT_C_ALT_FUNCTION:    next_rdata = {4'h0, c_cfg.alt};
      default:
      begin
        next_rdata = 8'h00;
        next_rhit  = 1'b0;
      end
    endcase
  end

  // read channel: data is captured with the address and held until taken
  assign rd_take       = (rd_state == gpio_ports_pkg::CH_IDLE) & s_axi_arvalid & ce_i;
  assign s_axi_arready = rd_take;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_state     <= gpio_ports_pkg::CH_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (ce_i)
    begin
      unique case (rd_state)
        gpio_ports_pkg::CH_IDLE:
        begin
          if (rd_take)
          begin
            rd_state     <= gpio_ports_pkg::CH_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, next_rdata};
            s_axi_rresp  <= next_rhit ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        gpio_ports_pkg::CH_RESP:
        begin
          if (s_axi_rready)
          begin
            rd_state     <= gpio_ports_pkg::CH_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule

// ---- src/gpio_ports_defs.svh ----
`ifndef GPIO_PORTS_DEFS_SVH
`define GPIO_PORTS_DEFS_SVH

// register byte offsets on the AXI4-Lite slave
`define OFS_ANALOG_PORT_PIN_LEVELS 8'h00
`define OFS_PORT_B_DATA            8'h04
`define OFS_PORT_B_DIRECTION       8'h08
`define OFS_PORT_B_ALT_FUNCTION    8'h0c
`define OFS_PORT_C_DATA            8'h10
`define OFS_PORT_C_DIRECTION       8'h14
`define OFS_PORT_C_ALT_FUNCTION    8'h18

// reset values of the port b and port c registers
`define RST_PORT_B 5'h00
`define RST_PORT_C 4'h0

// register positions of the five port b bits
`define POS_B0 0
`define POS_B1 1
`define POS_B2 2
`define POS_B3 6
`define POS_B4 7

// physical index of the port b bit that drives low in alternate mode
`define IDX_B_FIXED_LOW 2
// physical index of the port c bit that drives low in alternate mode
`define IDX_C_FIXED_LOW 0

// axi response codes
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- src/gpio_ports_pkg.sv ----
package gpio_ports_pkg;

  // configuration of one bidirectional port, physical bit order
  typedef struct packed {
    logic [4:0] data;  // port data register
    logic [4:0] dir;   // 1 = output
    logic [4:0] alt;   // 1 = alternate function
  } port_b_cfg_type;

  typedef struct packed {
    logic [3:0] data;  // port data register
    logic [3:0] dir;   // 1 = output
    logic [3:0] alt;   // 1 = alternate function
  } port_c_cfg_type;

  // axi channel handling
  typedef enum logic {
    CH_IDLE,
    CH_RESP
  } chan_state_type;

endpackage

// ---- testbench/gpio_pins_model.sv ----
`timescale 1ns/10ps
// board side of the pins: drivers, pull-ups and a floating line
module gpio_pins_model (
  input  wire logic       mclk_i,     // cpu clock
  input  wire logic [4:0] b_drv_i,    // port b drive value
  input  wire logic [4:0] b_oe_i,     // port b drive enable
  input  wire logic [4:0] b_pu_i,     // port b pull-up enable
  input  wire logic [4:0] b_ext_i,    // external level on port b
  input  wire logic [4:0] b_ext_en_i, // external driver present
  output logic      [4:0] b_pin_o,    // resolved port b level
  input  wire logic [3:0] c_drv_i,    // port c drive value
  input  wire logic [3:0] c_oe_i,     // port c drive enable
  input  wire logic [3:0] c_pu_i,     // port c pull-up enable
  input  wire logic [3:0] c_ext_i,    // external level on port c
  input  wire logic [3:0] c_ext_en_i, // external driver present
  output logic      [3:0] c_pin_o     // resolved port c level
);
  logic [4:0] b_last = 5'h00;  // last level, inverted while floating
  logic [3:0] c_last = 4'h0;

  // an undriven line without pull-up keeps no value, so it toggles
  always @(posedge mclk_i)
  begin
    b_last <= b_pin_o;
    c_last <= c_pin_o;
  end

  // pull-up wins only where nobody drives; input shared by peripherals
  assign b_pin_o = (b_oe_i & b_drv_i) | (~b_oe_i & b_ext_en_i & b_ext_i)
    | (~b_oe_i & ~b_ext_en_i & (b_pu_i | ~b_last));
  assign c_pin_o = (c_oe_i & c_drv_i) | (~c_oe_i & c_ext_en_i & c_ext_i)
    | (~c_oe_i & ~c_ext_en_i & (c_pu_i | ~c_last));
endmodule

// ---- testbench/gpio_ports_asserts.sv ----
`timescale 1ns/10ps
// sees only the block's ports; every rule here lives on the cpu clock
module gpio_ports_asserts (
  input wire logic        mclk_i,                 // cpu clock
  input wire logic        resetn_i,               // async reset, low
  input wire logic        ce_i,                   // clock enable
  input wire logic        s_axi_awvalid,          // write address valid
  input wire logic        s_axi_awready,          // write address ready
  input wire logic        s_axi_wvalid,           // write data valid
  input wire logic        s_axi_bvalid,           // write response valid
  input wire logic        s_axi_bready,           // write response ready
  input wire logic [1:0]  s_axi_bresp,            // write response
  input wire logic        s_axi_arvalid,          // read address valid
  input wire logic        s_axi_arready,          // read address ready
  input wire logic        s_axi_rvalid,           // read data valid
  input wire logic [31:0] s_axi_rdata,            // read data
  input wire logic [7:0]  analog_pin_i,           // input-only pins
  input wire logic [7:0]  analog_input_o,         // converter feed
  input wire logic [4:0]  port_b_pin_i,           // port b levels
  input wire logic [4:0]  port_b_pin_oe_o,        // port b drive enable
  input wire logic [4:0]  port_b_pullup_o,        // port b pull-ups
  input wire logic [3:0]  port_c_pin_oe_o,        // port c drive enable
  input wire logic [3:0]  port_c_pullup_o,        // port c pull-ups
  input wire logic        serial_five_data_in_o   // synced b2 level
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // converter input is a straight copy, sampled nowhere
  analog_pass_a: assert property (analog_input_o == analog_pin_i)
    else $error("converter input differs from pin");
  // a driven pin never has its pull-up on as well
  pull_excl_a: assert property (((port_b_pin_oe_o & port_b_pullup_o) == 5'h00) &&
    ((port_c_pin_oe_o & port_c_pullup_o) == 4'h0))
    else $error("pull-up on a driven pin");
  // for three cycles after reset release every pin floats
  reset_quiet_a: assert property ($rose(resetn_i) |->
    ({port_b_pin_oe_o, port_b_pullup_o, port_c_pin_oe_o, port_c_pullup_o} == 18'h0)[*3])
    else $error("pin driven or pulled right after reset");
  // only the low byte carries a register
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // a held level must come through the synchroniser in bounded time
  sync_pass_a: assert property ((port_b_pin_i[2] == $past(port_b_pin_i[2]))[*8] |->
    serial_five_data_in_o == port_b_pin_i[2])
    else $error("synced level does not follow pin");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && ce_i
    |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce_i |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule

// ---- testbench/gpio_ports_tb_top.sv ----
`timescale 1ns/10ps
`include "gpio_ports_defs.svh"
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("Error at %0t ns: got %h", $time, (got)); end end
module gpio_ports_tb_top;
  logic        mclk_i = 1'b0, resetn_i = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, analog_pin_i = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [6:0]  per = 7'h00;  // peripheral outputs: sck sdo ao0 ao1 txd rxc txc
  logic [4:0]  b_ext = 5'h00, b_en = 5'h1f, b_d, b_dir, b_alt;
  logic [3:0]  c_ext = 4'h0, c_en = 4'hf, c_d, c_dir, c_alt;
  logic [7:0]  ofs [7] = '{`OFS_ANALOG_PORT_PIN_LEVELS, `OFS_PORT_B_DATA, `OFS_PORT_B_DIRECTION,
    `OFS_PORT_B_ALT_FUNCTION, `OFS_PORT_C_DATA, `OFS_PORT_C_DIRECTION, `OFS_PORT_C_ALT_FUNCTION};
  logic [33:0] rq [$];  // expected {rresp, rdata}
  logic [1:0]  bq [$];  // expected bresp
  int          fails = 0, n_tests = 0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [7:0]   ain;
  wire [4:0]   b_pin, b_out, b_oe, b_pu;
  wire [3:0]   c_pin, c_out, c_oe, c_pu;
  wire [4:0]   syn;  // synced pin levels b0 b2 c0 c2 c3

  always #50 mclk_i = ~mclk_i;

  gpio_ports dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .analog_pin_i(analog_pin_i), .analog_input_o(ain), .port_b_pin_i(b_pin),
    .port_b_pin_o(b_out), .port_b_pin_oe_o(b_oe), .port_b_pullup_o(b_pu),
    .port_c_pin_i(c_pin), .port_c_pin_o(c_out), .port_c_pin_oe_o(c_oe), .port_c_pullup_o(c_pu),
    .serial_five_clock_i(per[0]), .serial_five_data_out_i(per[1]),
    .analog_output_zero_i(per[2]), .analog_output_one_i(per[3]),
    .async_six_transmit_data_i(per[4]), .async_six_receive_clock_i(per[5]),
    .async_six_transmit_clock_i(per[6]), .serial_five_clock_in_o(syn[0]),
    .serial_five_data_in_o(syn[1]), .async_six_receive_data_o(syn[2]),
    .async_six_receive_clock_in_o(syn[3]), .async_six_transmit_clock_in_o(syn[4]));

  gpio_pins_model pins (.mclk_i(mclk_i), .b_drv_i(b_out), .b_oe_i(b_oe), .b_pu_i(b_pu),
    .b_ext_i(b_ext), .b_ext_en_i(b_en), .b_pin_o(b_pin), .c_drv_i(c_out), .c_oe_i(c_oe),
    .c_pu_i(c_pu), .c_ext_i(c_ext), .c_ext_en_i(c_en), .c_pin_o(c_pin));

  // results are looked at half a cycle before the edge that takes them
  always @(negedge mclk_i)
  begin
    if (rvalid)
      `CHECK({rresp, rdata}, rq.pop_front())
    if (bvalid && s_axi_bready)
      `CHECK(bresp, bq.pop_front())
  end

  // physical port b bits sit at register bits 0,1,2,6,7
  function automatic logic [7:0] spread(input logic [4:0] v);
    return {v[4:3], 3'b000, v[2:0]};
  endfunction

  // ready is sampled at the falling edge, inputs are frozen until the rising one
  task automatic wait_for(input int k);
    int   n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 100)
    begin
      @(negedge mclk_i);
      hit = (k == 0) ? (awready && wready) === 1'b1 : (k == 1) ? bvalid === 1'b1 :
            (k == 2) ? arready === 1'b1 : rvalid === 1'b1;
      n++;
      @(posedge mclk_i);
    end
    if (!hit)
    begin
      fails++;
      $display("Error at %0t ns: handshake missing", $time);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
    bq.push_back(resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= {8'(a), 8'($urandom), 8'h5a, d};  // upper bytes are ignored
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    wait_for(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    // late bready: the answer must stand meanwhile
    @(posedge mclk_i);
    s_axi_bready <= 1'b1;
    wait_for(1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
    rq.push_back({resp, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wait_for(2);
    s_axi_arvalid <= 1'b0;
    wait_for(3);
  endtask

  // read mux: pin when input, data when output, peripheral when output and alternate
  task automatic check_all(input logic [4:0] pb, input logic [3:0] pc);
    logic [4:0] fb;
    logic [3:0] fc;
    fb = {per[3], per[2], 1'b0, per[1], per[0]};  // b2 alternate is fixed low
    fc = {per[6], per[5], per[4], 1'b0};  // c0 alternate is fixed low
    repeat (8) @(posedge mclk_i);
    `CHECK(b_oe, b_dir)
    `CHECK(c_oe, c_dir)
    `CHECK({b_pu, c_pu}, {~b_dir & b_alt, ~c_dir & c_alt})
    `CHECK(b_out & b_dir, b_dir & ((b_alt & fb) | (~b_alt & b_d)))
    `CHECK(c_out & c_dir, c_dir & ((c_alt & fc) | (~c_alt & c_d)))
    `CHECK(syn, {c_pin[3:2], c_pin[0], b_pin[2], b_pin[0]})
    `CHECK(ain, analog_pin_i)
    rd(ofs[0], analog_pin_i, `RESP_OKAY);
    rd(ofs[1], spread((b_dir & b_alt & fb) | (b_dir & ~b_alt & b_d) | (~b_dir & pb)),
      `RESP_OKAY);
    rd(ofs[2], spread(b_dir), `RESP_OKAY);
    rd(ofs[3], spread(b_alt), `RESP_OKAY);
    rd(ofs[4], {4'h0, (c_dir & c_alt & fc) | (c_dir & ~c_alt & c_d) | (~c_dir & pc)},
      `RESP_OKAY);
    rd(ofs[5], {4'h0, c_dir}, `RESP_OKAY);
    rd(ofs[6], {4'h0, c_alt}, `RESP_OKAY);
  endtask

  task automatic set_reg(input int r, input logic [7:0] v);
    wr(ofs[r], v, `RESP_OKAY);
    case (r)
      1: b_d = {v[7:6], v[2:0]};
      2: b_dir = {v[7:6], v[2:0]};
      3: b_alt = {v[7:6], v[2:0]};
      4: c_d = v[3:0];
      5: c_dir = v[3:0];
      default: c_alt = v[3:0];
    endcase
  endtask

  task automatic reset_dut(input int n);
    resetn_i <= 1'b0;
    repeat (n) @(posedge mclk_i);
    resetn_i <= 1'b1;
    {b_d, b_dir, b_alt, c_d, c_dir, c_alt} = 27'h0;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #(100 * 20000);
    fails++;
    finish_test;
  end

  initial
  begin
    void'($urandom(6476));
    @(posedge mclk_i);
    reset_dut(20);
    check_all(b_ext, c_ext);
    rd(8'h1c, 8'h00, `RESP_SLVERR);
    wr(ofs[0], 8'hff, `RESP_SLVERR);
    wr(8'h40, 8'hff, `RESP_SLVERR);
    for (int i = 0; i < 20; i++)
    begin
      analog_pin_i <= 8'($urandom);
      per <= 7'($urandom);
      b_ext <= 5'($urandom);
      c_ext <= 4'($urandom);
      for (int r = 1; r < 7; r++)
        set_reg(r, 8'($urandom));
      check_all(b_ext, c_ext);
    end
    // floating inputs with alternate set must read high through the pull-ups
    b_en <= 5'h00;
    c_en <= 4'h0;
    set_reg(2, 8'h00);
    set_reg(3, 8'hc7);
    set_reg(5, 8'h00);
    set_reg(6, 8'h0f);
    check_all(5'h1f, 4'hf);
    b_en <= 5'h1f;
    c_en <= 4'hf;
    // toggle two bits of the value the read mux gives, then drive it out
    set_reg(3, 8'h00);
    set_reg(6, 8'h00);
    check_all(b_ext, c_ext);
    set_reg(1, spread(b_ext) ^ 8'h41);
    set_reg(4, {4'h0, c_ext ^ 4'h9});
    set_reg(2, 8'hff);
    set_reg(5, 8'hff);
    check_all(b_ext, c_ext);
    reset_dut(3);
    check_all(b_ext, c_ext);
    finish_test;
  end
endmodule

bind gpio_ports gpio_ports_asserts chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .analog_pin_i(analog_pin_i), .analog_input_o(analog_input_o),
  .port_b_pin_i(port_b_pin_i), .port_b_pin_oe_o(port_b_pin_oe_o),
  .port_b_pullup_o(port_b_pullup_o), .port_c_pin_oe_o(port_c_pin_oe_o),
  .port_c_pullup_o(port_c_pullup_o), .serial_five_data_in_o(serial_five_data_in_o));
